// File: irs_defines.svh
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------------------
// Fixed upper part of the 7-bit slave address
`define IRS_ADDR_HI 5'h0A
// Data bits in one byte on the link
`define IRS_BYTE_BITS 4'h8
// Register address and data widths
`define IRS_RA_W 7
`define IRS_DW 8
// Register index of the data FIFO (plain default)
`define IRS_FIFO_ADDR 7'h05

// ----------------------------------------------------------------------------
// Synchroniser depth and strap width
// ----------------------------------------------------------------------------
`define IRS_SYNC_N 3
`define IRS_CFG_W 6

`endif

// File: irs_pkg.sv
`include "irs_defines.svh"

package irs_pkg;

  // --------------------------------------------------------------------------
  // Link state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IRS_IDLE,
    IRS_RX,
    IRS_RX_ACK,
    IRS_TX,
    IRS_TX_ACK
  } irs_state_t;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    IRS_K_DEV,
    IRS_K_REG,
    IRS_K_DATA
  } irs_kind_t;

  // Register access handed from the link domain to the core domain
  typedef struct packed {
    logic wr;
    logic [`IRS_RA_W-1:0] addr;
    logic [`IRS_DW-1:0] wdata;
  } irs_req_t;

  // All state clocked by the link clock
  typedef struct packed {
    logic [`IRS_SYNC_N-1:0] scl_s;
    logic scl_v;
    logic [`IRS_SYNC_N-1:0] sda_s;
    logic sda_v;
    logic [`IRS_SYNC_N-1:0] ack_s;
    logic ack_v;
    logic [`IRS_SYNC_N-1:0][`IRS_CFG_W-1:0] cfg_s;
    logic [`IRS_CFG_W-1:0] cfg_v;
    irs_state_t st;
    irs_kind_t kind;
    logic rd;
    logic [3:0] cnt;
    logic [`IRS_DW-1:0] sh;
    logic [`IRS_RA_W-1:0] ptr;
    logic drv;
    logic sdo;
    irs_req_t req;
    logic req_tgl;
    logic [`IRS_DW-1:0] rdata;
  } irs_link_t;

  // All state clocked by the core clock
  typedef struct packed {
    logic [`IRS_SYNC_N-1:0] req_s;
    logic req_v;
    logic wr;
    logic rd;
    logic rd_wait;
    logic [`IRS_RA_W-1:0] addr;
    logic [`IRS_DW-1:0] wdata;
    logic [`IRS_DW-1:0] rdata;
    logic ack_tgl;
  } irs_core_t;

endpackage : irs_pkg

// File: irs_slave.sv
`timescale 1ns/1ps
`include "irs_defines.svh"

// How it works
// - Acknowledge bit follows every transferred byte
// - Sender releases SDA, receiver holds low
// - Master nack ends read; slave releases SDA
// - First byte addresses; only matching slave answers
// - Upper five address bits fixed 01010
// - Low two bits from pins or stored value
// - Write: address, register index, data bytes
// - Non-FIFO writes go to consecutive registers
// - FIFO writes all push, pointer holds
// - Read returns addressed then following registers
// - FIFO reads keep the pointer fixed
// - Short-range variant: same protocol, 5 Mbaud
// - Short-range pin option forces upper bit 0
// - Short-range link is point to point
// - Master always drives clock, no stretching
// - Each party owns its SDA enable
// - Short-range: drive SDA only while SCL low
// - Short-range: bus keeper holds last SDA level
// - Slave only, never stretches the clock
// - General call ignored, no soft reset
// - Bytes shift most significant bit first
// - Start and stop are SDA edges, SCL high
module irs_slave #(
  parameter logic [`IRS_RA_W-1:0] FIFO_ADDR = `IRS_FIFO_ADDR
) (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  // Serial link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Bus keeper on SDA
  output logic o_keep_o,
  output logic o_keep_oe,
  // Configuration straps
  input wire logic i_short_range,
  input wire logic i_adr_from_nv,
  input wire logic [1:0] i_adr_pins,
  input wire logic [1:0] i_adr_nv,
  // Register and FIFO access
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [`IRS_RA_W-1:0] o_reg_addr,
  output logic [`IRS_DW-1:0] o_reg_wdata,
  input wire logic [`IRS_DW-1:0] i_reg_rdata
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (`IRS_RA_W != 7) begin : g_bad_width
    $error("register address must be seven bits wide");
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // A level counts once the second and third stages agree
  function automatic logic irs_filt(input logic [`IRS_SYNC_N-1:0] s, input logic v);
    irs_filt = (s[1] == s[2]) ? s[2] : v;
  endfunction : irs_filt

  // Auto-increment, held on the FIFO and wrapping at the top
  function automatic logic [`IRS_RA_W-1:0] irs_next_ptr(input logic [`IRS_RA_W-1:0] p);
    irs_next_ptr = (p == FIFO_ADDR) ? p : p + 7'h01;
  endfunction : irs_next_ptr

  // --------------------------------------------------------------------------
  // Reset release, one copy per domain
  // --------------------------------------------------------------------------
  logic [1:0] core_rst_q;
  logic [1:0] link_rst_q;
  logic core_rstn;
  logic link_rstn;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      core_rst_q <= '0;
    end else begin
      core_rst_q <= {core_rst_q[0], 1'h1};
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      link_rst_q <= '0;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'h1};
    end
  end

  assign core_rstn = core_rst_q[1];
  assign link_rstn = link_rst_q[1];

  irs_pkg::irs_link_t l_q;
  irs_pkg::irs_link_t l_d;
  irs_pkg::irs_core_t c_q;
  irs_pkg::irs_core_t c_d;

  // --------------------------------------------------------------------------
  // Link domain
  // --------------------------------------------------------------------------
  logic scl_n;
  logic sda_n;
  logic ack_n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic short_rng;
  logic [1:0] my_low;
  logic [`IRS_CFG_W-1:0] cfg_pin;

  assign cfg_pin = {i_short_range, i_adr_from_nv, i_adr_pins, i_adr_nv};
  assign short_rng = l_q.cfg_v[5];

  always_comb begin
    l_d = l_q;
    l_d.scl_s = {l_q.scl_s[1:0], i_scl};
    l_d.sda_s = {l_q.sda_s[1:0], i_sda};
    l_d.ack_s = {l_q.ack_s[1:0], c_q.ack_tgl};
    l_d.cfg_s = {l_q.cfg_s[1:0], cfg_pin};
    if (l_q.cfg_s[1] == l_q.cfg_s[2]) begin
      l_d.cfg_v = l_q.cfg_s[2];
    end
    scl_n = irs_filt(l_q.scl_s, l_q.scl_v);
    sda_n = irs_filt(l_q.sda_s, l_q.sda_v);
    ack_n = irs_filt(l_q.ack_s, l_q.ack_v);
    l_d.scl_v = scl_n;
    l_d.sda_v = sda_n;
    l_d.ack_v = ack_n;
    rise = scl_n & ~l_q.scl_v;
    fall = ~scl_n & l_q.scl_v;
    start = l_q.scl_v & scl_n & l_q.sda_v & ~sda_n;
    stop = l_q.scl_v & scl_n & ~l_q.sda_v & sda_n;
    // Pin option has only one usable pin on the short-range link
    if (l_q.cfg_v[4]) begin
      my_low = l_q.cfg_v[1:0];
    end else if (short_rng) begin
      my_low = {1'h0, l_q.cfg_v[2]};
    end else begin
      my_low = l_q.cfg_v[3:2];
    end
    if (ack_n != l_q.ack_v) begin
      l_d.rdata = c_q.rdata;
    end
    if (start) begin
      l_d.st = irs_pkg::IRS_RX;
      l_d.kind = irs_pkg::IRS_K_DEV;
      l_d.cnt = '0;
      l_d.drv = 1'h0;
    end else if (stop) begin
      l_d.st = irs_pkg::IRS_IDLE;
      l_d.drv = 1'h0;
    end else begin
      unique case (l_q.st)
        irs_pkg::IRS_IDLE: begin
          l_d.drv = 1'h0;
        end
        irs_pkg::IRS_RX: begin
          if (rise && l_q.cnt != `IRS_BYTE_BITS) begin
            l_d.sh = {l_q.sh[6:0], sda_n};
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (fall && l_q.cnt == `IRS_BYTE_BITS) begin
            l_d.st = irs_pkg::IRS_RX_ACK;
            l_d.drv = 1'h1;
            l_d.sdo = 1'h0;
            unique case (l_q.kind)
              irs_pkg::IRS_K_DEV: begin
                // The fixed upper bits are non-zero, so a general call never matches
                if (l_q.sh[7:1] == {`IRS_ADDR_HI, my_low}) begin
                  l_d.rd = l_q.sh[0];
                  if (l_q.sh[0]) begin
                    l_d.req = '{wr: 1'h0, addr: l_q.ptr, wdata: '0};
                    l_d.req_tgl = ~l_q.req_tgl;
                  end
                end else begin
                  l_d.st = irs_pkg::IRS_IDLE;
                  l_d.drv = 1'h0;
                end
              end
              irs_pkg::IRS_K_REG: begin
                l_d.ptr = l_q.sh[6:0];
              end
              default: begin
                l_d.req = '{wr: 1'h1, addr: l_q.ptr, wdata: l_q.sh};
                l_d.req_tgl = ~l_q.req_tgl;
                l_d.ptr = irs_next_ptr(l_q.ptr);
              end
            endcase
          end
        end
        irs_pkg::IRS_RX_ACK: begin
          // Short-range keeper carries the low level through the high phase
          if (rise && short_rng) begin
            l_d.drv = 1'h0;
          end
          if (fall) begin
            l_d.drv = 1'h0;
            l_d.cnt = '0;
            if (l_q.kind == irs_pkg::IRS_K_DEV && l_q.rd) begin
              l_d.st = irs_pkg::IRS_TX;
              l_d.sh = l_q.rdata;
              l_d.drv = 1'h1;
              l_d.sdo = l_q.rdata[7];
            end else begin
              l_d.st = irs_pkg::IRS_RX;
              l_d.kind = (l_q.kind == irs_pkg::IRS_K_DEV) ? irs_pkg::IRS_K_REG :
                         irs_pkg::IRS_K_DATA;
            end
          end
        end
        irs_pkg::IRS_TX: begin
          if (rise) begin
            l_d.cnt = l_q.cnt + 4'h1;
            if (short_rng) begin
              l_d.drv = 1'h0;
            end
          end
          if (fall) begin
            if (l_q.cnt == `IRS_BYTE_BITS) begin
              l_d.st = irs_pkg::IRS_TX_ACK;
              l_d.drv = 1'h0;
            end else begin
              l_d.sh = {l_q.sh[6:0], 1'h0};
              l_d.drv = 1'h1;
              l_d.sdo = l_q.sh[6];
            end
          end
        end
        irs_pkg::IRS_TX_ACK: begin
          if (rise) begin
            if (!sda_n) begin
              l_d.ptr = irs_next_ptr(l_q.ptr);
              l_d.req = '{wr: 1'h0, addr: irs_next_ptr(l_q.ptr), wdata: '0};
              l_d.req_tgl = ~l_q.req_tgl;
            end else begin
              l_d.st = irs_pkg::IRS_IDLE;
            end
          end
          if (fall) begin
            l_d.st = irs_pkg::IRS_TX;
            l_d.cnt = '0;
            l_d.sh = l_q.rdata;
            l_d.drv = 1'h1;
            l_d.sdo = l_q.rdata[7];
          end
        end
        default: begin
          l_d.st = irs_pkg::IRS_IDLE;
          l_d.drv = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // --------------------------------------------------------------------------
  // Core domain: performs the register accesses handed over by toggle
  // --------------------------------------------------------------------------
  logic req_n;

  always_comb begin
    c_d = c_q;
    c_d.req_s = {c_q.req_s[1:0], l_q.req_tgl};
    req_n = irs_filt(c_q.req_s, c_q.req_v);
    c_d.req_v = req_n;
    c_d.wr = 1'h0;
    c_d.rd = 1'h0;
    c_d.rd_wait = c_q.rd;
    // Request fields were loaded with the toggle and stay still until the next one
    if (req_n != c_q.req_v) begin
      c_d.addr = l_q.req.addr;
      c_d.wdata = l_q.req.wdata;
      c_d.wr = l_q.req.wr;
      c_d.rd = ~l_q.req.wr;
    end
    if (c_q.rd_wait) begin
      c_d.rdata = i_reg_rdata;
      c_d.ack_tgl = ~c_q.ack_tgl;
    end
  end

  always_ff @(posedge i_clk or negedge core_rstn) begin
    if (!core_rstn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Clock is never driven: no stretching, slave only
  assign o_sda_o = l_q.sdo;
  // Open drain drives lows only; short-range drives both levels, never with SCL high
  assign o_sda_oe = l_q.drv & (short_rng | ~l_q.sdo) & ~(short_rng & i_scl);
  assign o_keep_o = l_q.sda_v;
  assign o_keep_oe = short_rng;
  assign o_reg_wr = c_q.wr;
  assign o_reg_rd = c_q.rd;
  assign o_reg_addr = c_q.addr;
  assign o_reg_wdata = c_q.wdata;

endmodule : irs_slave

// File: irs_slave_sva.sv
`timescale 1ns/1ps
`include "irs_defines.svh"
module irs_slave_sva (
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  // Link
  input wire logic i_scl,
  input wire logic i_short_range,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_keep_oe,
  // Register port
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic [`IRS_RA_W-1:0] o_reg_addr
);
  // --------------------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------------------
  sequence s_quiet;
    !o_reg_wr && !o_reg_rd;
  endsequence
  // Mode has to outlast the strap synchroniser before the keeper may follow
  sequence s_sr_on;
    i_short_range [*8] ##1 i_short_range [*4];
  endsequence
  sequence s_sr_off;
    !i_short_range [*8] ##1 !i_short_range [*4];
  endsequence
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  a_wr_spacing: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_reg_wr |=> s_quiet [*8]) else $error("write pulse not followed by a quiet gap");
  a_rd_spacing: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_reg_rd |=> s_quiet [*8]) else $error("read pulse not followed by a quiet gap");
  a_addr_moves: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $changed(o_reg_addr) |-> o_reg_wr || o_reg_rd) else $error("index moved without access");
  a_sr_scl_high: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    o_keep_oe && i_scl |-> !o_sda_oe) else $error("data driven while clock high");
  a_std_low_only: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    !i_short_range && !o_keep_oe && o_sda_oe |-> !o_sda_o) else $error("open drain drove high");
  a_std_edge_low: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    !o_keep_oe && $changed(o_sda_oe) |-> !i_scl) else $error("data enable moved, clock high");
  a_keeper_on: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    s_sr_on |-> o_keep_oe) else $error("keeper missing in short range");
  a_keeper_off: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
    s_sr_off |-> !o_keep_oe) else $error("keeper active in standard mode");
endmodule : irs_slave_sva

bind irs_slave irs_slave_sva i_irs_slave_sva (.i_clk, .i_rstn, .i_link_clk, .i_scl,
  .i_short_range, .o_sda_o, .o_sda_oe, .o_keep_oe, .o_reg_wr, .o_reg_rd, .o_reg_addr);

// File: irs_master_model.sv
`timescale 1ns/1ps
module irs_master_model (
  // Mode and wire level
  input wire logic i_clk,
  input wire logic i_sr,
  input wire logic i_sda,
  // Master drive
  output logic o_scl,
  output logic o_sda_o,
  output logic o_sda_oe
);
  // 20 core cycles a half bit keeps both clock phases above 100 ns
  localparam int HALF = 20;
  initial begin
    o_scl = 1'b1;
    o_sda_o = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Standard mode is open drain: a high is left to the pull-up
  task automatic step(input logic scl, input logic sda, input logic drv);
    repeat (HALF) @(posedge i_clk);
    o_scl <= scl;
    o_sda_o <= sda;
    o_sda_oe <= drv && (i_sr || !sda);
  endtask : step
  task automatic bit_io(input logic b, input logic drv, output logic r);
    step(1'b0, b, drv);
    step(1'b1, b, drv && !i_sr);
    repeat (8) @(posedge i_clk);
    r = i_sda;
  endtask : bit_io
  task automatic start_c();
    step(1'b0, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b1);
  endtask : start_c
  task automatic stop_c();
    step(1'b0, 1'b0, 1'b1);
    step(1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b1);
  endtask : stop_c
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], 1'b1, r);
    bit_io(1'b1, 1'b0, r);
    ack = !r;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 1'b0, r);
      d[i] = r;
    end
    bit_io(!ack, 1'b1, r);
  endtask : recv
endmodule : irs_master_model

// File: tb_irs_slave.sv
`timescale 1ns/1ps
`include "irs_defines.svh"
module tb_irs_slave;
  localparam logic [6:0] FA = `IRS_FIFO_ADDR;
  logic clk, link_clk, rstn, scl, m_o, m_oe, sda_o, sda_oe, keep_o, keep_oe, sr, nv_sel, wr, rd;
  logic [1:0] pins, nv, low;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, idx;
  logic [7:0] mem [128];
  logic [7:0] exp_mem [128];
  logic [14:0] exp_wr [$];
  logic [7:0] fifo [$];
  logic [7:0] exp_fifo [$];
  int bad_count, comparisons;
  int drive_cnt = 0;
  // Slave, then master, then keeper, then the pull-up of the standard bus
  wire sda = sda_oe ? sda_o : (m_oe ? m_o : (keep_oe ? keep_o : 1'b1));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  irs_slave #(.FIFO_ADDR(FA)) i_irs_slave (.i_clk(clk), .i_rstn(rstn), .i_link_clk(link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_keep_o(keep_o),
    .o_keep_oe(keep_oe), .i_short_range(sr), .i_adr_from_nv(nv_sel), .i_adr_pins(pins),
    .i_adr_nv(nv), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata),
    .i_reg_rdata(rdata));
  irs_master_model i_irs_master_model (.i_clk(clk), .i_sr(sr), .i_sda(sda), .o_scl(scl),
    .o_sda_o(m_o), .o_sda_oe(m_oe));
  task automatic check(input logic [14:0] seen, input logic [14:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  // Register file and FIFO behind the port
  always @(posedge clk) begin
    if (sda_oe) drive_cnt <= drive_cnt + 1;
    if (wr) begin
      check({addr, wdata}, exp_wr.size() ? exp_wr.pop_front() : 15'hx, "write");
      if (addr == FA) fifo.push_back(wdata);
      else mem[addr] = wdata;
    end
    if (rd) rdata <= (addr != FA) ? mem[addr] : (fifo.size() ? fifo.pop_front() : 8'hx);
    else rdata <= 8'($urandom);
  end
  task automatic wr_frame(input logic [6:0] dev, input logic [7:0] ix, input int n, input logic ok);
    logic a;
    logic [7:0] d;
    logic [6:0] p;
    int c0;
    p = ix[6:0];
    c0 = drive_cnt;
    i_irs_master_model.start_c();
    i_irs_master_model.send({dev, 1'b0}, a);
    // A released short-range line keeps the last bit sent, so a low there reads as ack
    check(15'(a), 15'(ok || sr), "address ack");
    i_irs_master_model.send(ix, a);
    check(15'(a), 15'(ok || (sr && !ix[0])), "index ack");
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      // Expected write is queued first: the port pulses inside the ack slot
      if (ok) begin
        exp_wr.push_back({p, d});
        if (p == FA) exp_fifo.push_back(d);
        else exp_mem[p] = d;
        if (p != FA) p = p + 7'h01;
      end
      i_irs_master_model.send(d, a);
      check(15'(a), 15'(ok || (sr && !d[0])), "data ack");
    end
    i_irs_master_model.stop_c();
    check(15'(drive_cnt != c0), 15'(ok), "slave drive");
  endtask : wr_frame
  task automatic rd_frame(input logic [6:0] dev, input logic [7:0] ix, input int n);
    logic a;
    logic [7:0] d;
    logic [6:0] p;
    p = ix[6:0];
    i_irs_master_model.start_c();
    i_irs_master_model.send({dev, 1'b0}, a);
    i_irs_master_model.send(ix, a);
    i_irs_master_model.start_c();
    i_irs_master_model.send({dev, 1'b1}, a);
    check(15'(a), 15'h1, "read address ack");
    for (int i = 0; i < n; i++) begin
      i_irs_master_model.recv(i < n - 1, d);
      check(15'(d), 15'(p == FA ? exp_fifo.pop_front() : exp_mem[p]), "read");
      if (p != FA) p = p + 7'h01;
    end
    i_irs_master_model.stop_c();
  endtask : rd_frame
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(47059));
    {rstn, sr, nv_sel, pins, nv, rdata} = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      sr <= t[1];
      nv_sel <= t[0];
      pins <= 2'($urandom);
      nv <= 2'($urandom);
      repeat (40) @(posedge clk);
      low = nv_sel ? nv : (sr ? {1'b0, pins[0]} : pins);
      idx = (t == 0) ? 8'hFE : (8'($urandom) | 8'h10);
      wr_frame({5'h0A, low}, idx, 3, 1'b1);
      wr_frame({5'h0A, ~low[1], low[0]}, idx, 2, 1'b0);
      wr_frame(7'h00, idx, 1, 1'b0);
      rd_frame({5'h0A, low}, idx, 3);
      wr_frame({5'h0A, low}, {1'b0, FA}, 3, 1'b1);
      rd_frame({5'h0A, low}, {1'b0, FA}, 2);
      check(15'(exp_wr.size()), 15'h0, "writes missing");
      check(15'(fifo.size()), 15'(exp_fifo.size()), "fifo level");
      $display("test %0d done", t);
    end
    give_verdict();
  end
endmodule : tb_irs_slave
